// ### common/mac_pkg.sv
/*
  constants and types shared by the ascii frame codec: character codes,
  address and length limits, state and drop-reason encodings.
  assumes one 40 mhz clock and an 8-bit character stream on either side.
*/
package mac_pkg;

  // ==========================================================
  // characters
  localparam logic [7:0] MAC_CHAR_START = 8'h3A;
  localparam logic [7:0] MAC_CHAR_CR = 8'h0D;
  localparam logic [7:0] MAC_CHAR_LF = 8'h0A;
  localparam logic [7:0] MAC_CHAR_DIGIT0 = 8'h30;
  localparam logic [7:0] MAC_CHAR_DIGIT9 = 8'h39;
  localparam logic [7:0] MAC_CHAR_LETTER_A = 8'h41;
  localparam logic [7:0] MAC_CHAR_LETTER_F = 8'h46;
  localparam logic [3:0] MAC_NIB_TEN = 4'hA;

  // ==========================================================
  // addresses, lengths, functions
  localparam logic [7:0] MAC_ADDR_BCAST = 8'h00;
  localparam logic [7:0] MAC_ADDR_MAX = 8'hFE;
  localparam logic [7:0] MAC_DATA_MAX = 8'hCD;
  localparam logic [7:0] MAC_FRAME_OVERHEAD = 8'h03;
  localparam logic [7:0] MAC_FUNC_READ_WORDS = 8'h03;
  localparam int MAC_READ_WORDS_MAX = 100;
  localparam logic [7:0] MAC_READ_BYTES_MAX = 8'(2 * MAC_READ_WORDS_MAX);

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    MAC_R_IDLE = 2'b00,
    MAC_R_BODY = 2'b01,
    MAC_R_LF = 2'b10
  } mac_rx_state_t;

  typedef enum logic [2:0] {
    MAC_T_IDLE = 3'b000,
    MAC_T_START = 3'b001,
    MAC_T_LOAD = 3'b010,
    MAC_T_HI = 3'b011,
    MAC_T_LO = 3'b100,
    MAC_T_CR = 3'b101,
    MAC_T_LF = 3'b110
  } mac_tx_state_t;

  typedef enum logic [2:0] {
    MAC_DROP_NONE = 3'b000,
    MAC_DROP_CHAR = 3'b001,
    MAC_DROP_LONG = 3'b010,
    MAC_DROP_SHORT = 3'b011,
    MAC_DROP_CHECK = 3'b100,
    MAC_DROP_ADDR = 3'b101
  } mac_drop_t;

endpackage

// ### hdl/mac_hex_codec.sv
/*
  nibble to ascii hex character and back, purely combinational.
  assumes callers register whatever they need to hold.
*/
`timescale 1ns/1ps
module mac_hex_codec (
  // encode side
  input wire logic [7:0] enc_byte,
  output logic [7:0] enc_hi_char,
  output logic [7:0] enc_lo_char,
  // decode side
  input wire logic [7:0] dec_char,
  output logic [3:0] dec_nib,
  output logic dec_ok
);

  // ==========================================================
  // encode, high nibble and low nibble
  function automatic logic [7:0] enc_nib(input logic [3:0] n);
    if (n < mac_pkg::MAC_NIB_TEN) begin
      enc_nib = mac_pkg::MAC_CHAR_DIGIT0 + {4'h0, n};
    end else begin
      enc_nib = mac_pkg::MAC_CHAR_LETTER_A + {4'h0, n - mac_pkg::MAC_NIB_TEN};
    end
  endfunction

  always_comb begin
    enc_hi_char = enc_nib(enc_byte[7:4]);
    enc_lo_char = enc_nib(enc_byte[3:0]);
  end

  // ==========================================================
  // decode, uppercase only
  always_comb begin
    dec_nib = 4'h0;
    dec_ok = 1'b0;
    if (dec_char >= mac_pkg::MAC_CHAR_DIGIT0 && dec_char <= mac_pkg::MAC_CHAR_DIGIT9) begin
      dec_nib = 4'(dec_char - mac_pkg::MAC_CHAR_DIGIT0);
      dec_ok = 1'b1;
    end else if (dec_char >= mac_pkg::MAC_CHAR_LETTER_A &&
                 dec_char <= mac_pkg::MAC_CHAR_LETTER_F) begin
      dec_nib = 4'(dec_char - mac_pkg::MAC_CHAR_LETTER_A) + mac_pkg::MAC_NIB_TEN;
      dec_ok = 1'b1;
    end
  end

endmodule

// ### hdl/mac_frame_mem.sv
/*
  simple dual-port byte store for received frame data.
  assumes one clock; read data appear one cycle after the read enable.
*/
`timescale 1ns/1ps
module mac_frame_mem #(
  parameter int DW = 8,
  parameter int AW = 8
) (
  // clock
  input wire logic ref_clk,
  // write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  // read port
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);

  // ==========================================================
  // storage
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

// ### hdl/mac_frame_codec.sv
/*
  ascii frame codec for the slave: parses incoming characters into checked
  frames held in a byte store, and turns a reply (function, length, data
  bytes) into a framed character stream with its check byte.
  assumes characters arrive synchronous to ref_clk, one per valid cycle.
*/
`timescale 1ns/1ps

// Behaviour
// - a frame starts with a colon, 0x3A; it begins a new frame
// - address follows start as two hex characters, one byte
// - function code follows address as two hex characters
// - data field holds n bytes as 2n characters, n at most 205
// - check byte follows data as two hex characters
// - frame ends with carriage return then line feed
// - nibbles 0-9 map to 0x30-0x39, 10-15 to uppercase 0x41-0x46
// - own station address valid only from 0 to 254; zero is broadcast
// - broadcast frames are acted on but never answered
// - a good frame for our nonzero address gets a reply
// - check byte is twos complement of byte sum, address through data
// - each byte is sent high nibble first
// - read-words replies carry at most 100 words
module mac_frame_codec #(
  parameter int AW = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // configuration
  input wire logic [7:0] own_addr,
  // received characters
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char,
  // received frame
  output logic rx_frame_valid,
  output logic rx_broadcast,
  output logic [7:0] rx_addr,
  output logic [7:0] rx_func,
  output logic [7:0] rx_len,
  output logic rx_drop,
  output logic [2:0] rx_drop_code,
  input wire logic rx_rd_en,
  input wire logic [AW-1:0] rx_rd_idx,
  output logic [7:0] rx_rd_data,
  // reply request
  output logic reply_req,
  input wire logic tx_start,
  input wire logic [7:0] tx_func,
  input wire logic [7:0] tx_len,
  output logic tx_refused,
  output logic tx_busy,
  input wire logic tx_byte_valid,
  input wire logic [7:0] tx_byte,
  output logic tx_byte_ready,
  // transmitted characters
  output logic tx_char_valid,
  output logic [7:0] tx_char,
  input wire logic tx_char_ready
);

  // ==========================================================
  // codec
  logic [7:0] enc_byte, enc_hi, enc_lo;
  logic [3:0] dec_nib;
  logic dec_ok;

  mac_hex_codec u_codec (
    .enc_byte(enc_byte),
    .enc_hi_char(enc_hi),
    .enc_lo_char(enc_lo),
    .dec_char(rx_char),
    .dec_nib(dec_nib),
    .dec_ok(dec_ok)
  );

  // ==========================================================
  // receive parser
  mac_pkg::mac_rx_state_t rs_q, rs_d;
  logic half_q, half_d;
  logic [3:0] hi_q, hi_d;
  logic [7:0] cnt_q, cnt_d, sum_q, sum_d, addr_q, addr_d, func_q, func_d, len_q, len_d;
  mac_pkg::mac_drop_t err_q, err_d, code_q, code_d;
  logic fv_q, fv_d, drop_q, drop_d, bc_q, bc_d, pend_q, pend_d;
  logic wr_en;
  logic [7:0] byte_in;
  logic own_ok, tx_go;

  assign byte_in = {hi_q, dec_nib};
  assign own_ok = (own_addr <= mac_pkg::MAC_ADDR_MAX);

  always_comb begin
    rs_d = rs_q;
    half_d = half_q;
    hi_d = hi_q;
    cnt_d = cnt_q;
    sum_d = sum_q;
    addr_d = addr_q;
    func_d = func_q;
    len_d = len_q;
    err_d = err_q;
    code_d = code_q;
    bc_d = bc_q;
    fv_d = 1'b0;
    drop_d = 1'b0;
    wr_en = 1'b0;
    if (rx_char_valid && rx_char == mac_pkg::MAC_CHAR_START) begin
      rs_d = mac_pkg::MAC_R_BODY;
      half_d = 1'b0;
      cnt_d = 8'h00;
      sum_d = 8'h00;
      err_d = mac_pkg::MAC_DROP_NONE;
    end else if (rx_char_valid) begin
      case (rs_q)
        mac_pkg::MAC_R_BODY: begin
          if (dec_ok && !half_q) begin
            hi_d = dec_nib;
            half_d = 1'b1;
          end else if (dec_ok) begin
            half_d = 1'b0;
            sum_d = sum_q + byte_in;
            if (cnt_q == 8'h00) begin
              addr_d = byte_in;
            end else if (cnt_q == 8'h01) begin
              func_d = byte_in;
            end
            if (cnt_q == mac_pkg::MAC_DATA_MAX + mac_pkg::MAC_FRAME_OVERHEAD) begin
              err_d = mac_pkg::MAC_DROP_LONG;
            end else begin
              wr_en = (cnt_q >= 8'h02);
              cnt_d = cnt_q + 8'h01;
            end
          end else if (rx_char == mac_pkg::MAC_CHAR_CR) begin
            rs_d = mac_pkg::MAC_R_LF;
            if (half_q || cnt_q < mac_pkg::MAC_FRAME_OVERHEAD) begin
              err_d = mac_pkg::MAC_DROP_SHORT;
            end
          end else begin
            rs_d = mac_pkg::MAC_R_IDLE;
            drop_d = 1'b1;
            code_d = mac_pkg::MAC_DROP_CHAR;
          end
        end
        mac_pkg::MAC_R_LF: begin
          rs_d = mac_pkg::MAC_R_IDLE;
          if (rx_char != mac_pkg::MAC_CHAR_LF) begin
            drop_d = 1'b1;
            code_d = mac_pkg::MAC_DROP_CHAR;
          end else if (err_q != mac_pkg::MAC_DROP_NONE) begin
            drop_d = 1'b1;
            code_d = err_q;
          end else if (sum_q != 8'h00) begin
            drop_d = 1'b1;
            code_d = mac_pkg::MAC_DROP_CHECK;
          end else if (addr_q == mac_pkg::MAC_ADDR_BCAST) begin
            fv_d = 1'b1;
            bc_d = 1'b1;
            len_d = cnt_q - mac_pkg::MAC_FRAME_OVERHEAD;
          end else if (own_ok && addr_q == own_addr) begin
            fv_d = 1'b1;
            bc_d = 1'b0;
            len_d = cnt_q - mac_pkg::MAC_FRAME_OVERHEAD;
          end else begin
            drop_d = 1'b1;
            code_d = mac_pkg::MAC_DROP_ADDR;
          end
        end
        default: begin
          rs_d = mac_pkg::MAC_R_IDLE;
        end
      endcase
    end
    // set wins over clear
    pend_d = pend_q;
    if (tx_go) begin
      pend_d = 1'b0;
    end
    if (fv_d && !bc_d) begin
      pend_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rs_q <= mac_pkg::MAC_R_IDLE;
      half_q <= 1'b0;
      hi_q <= 4'h0;
      cnt_q <= 8'h00;
      sum_q <= 8'h00;
      addr_q <= 8'h00;
      func_q <= 8'h00;
      len_q <= 8'h00;
      err_q <= mac_pkg::MAC_DROP_NONE;
      code_q <= mac_pkg::MAC_DROP_NONE;
      bc_q <= 1'b0;
      fv_q <= 1'b0;
      drop_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      rs_q <= rs_d;
      half_q <= half_d;
      hi_q <= hi_d;
      cnt_q <= cnt_d;
      sum_q <= sum_d;
      addr_q <= addr_d;
      func_q <= func_d;
      len_q <= len_d;
      err_q <= err_d;
      code_q <= code_d;
      bc_q <= bc_d;
      fv_q <= fv_d;
      drop_q <= drop_d;
      pend_q <= pend_d;
    end
  end

  mac_frame_mem #(.DW(8), .AW(AW)) u_mem (
    .ref_clk(ref_clk),
    .wr_en(wr_en),
    .wr_addr(AW'(cnt_q - 8'h02)),
    .wr_data(byte_in),
    .rd_en(rx_rd_en),
    .rd_addr(rx_rd_idx),
    .rd_data(rx_rd_data)
  );

  assign rx_frame_valid = fv_q;
  assign rx_broadcast = bc_q;
  assign rx_addr = addr_q;
  assign rx_func = func_q;
  assign rx_len = len_q;
  assign rx_drop = drop_q;
  assign rx_drop_code = code_q;
  assign reply_req = pend_q;

  // ==========================================================
  // transmit framer
  mac_pkg::mac_tx_state_t ts_q, ts_d;
  logic [7:0] ch_q, ch_d, cur_q, cur_d, idx_q, idx_d, tlen_q, tlen_d, tfunc_q, tfunc_d;
  logic [7:0] tsum_q, tsum_d, load_byte, len_cap;
  logic last_q, last_d, ref_q, ref_d, have;

  assign tx_go = tx_start && ts_q == mac_pkg::MAC_T_IDLE && pend_q;
  assign enc_byte = (ts_q == mac_pkg::MAC_T_LOAD) ? load_byte : cur_q;

  always_comb begin
    len_cap = (tx_len > mac_pkg::MAC_DATA_MAX) ? mac_pkg::MAC_DATA_MAX : tx_len;
    if (tx_func == mac_pkg::MAC_FUNC_READ_WORDS && tx_len > mac_pkg::MAC_READ_BYTES_MAX) begin
      len_cap = mac_pkg::MAC_READ_BYTES_MAX;
    end
    have = 1'b1;
    tx_byte_ready = 1'b0;
    load_byte = ~tsum_q + 8'h01;
    if (idx_q == 8'h00) begin
      load_byte = own_addr;
    end else if (idx_q == 8'h01) begin
      load_byte = tfunc_q;
    end else if ({1'b0, idx_q} < {1'b0, tlen_q} + 9'h002) begin
      load_byte = tx_byte;
      have = tx_byte_valid;
      tx_byte_ready = (ts_q == mac_pkg::MAC_T_LOAD);
    end
    ts_d = ts_q;
    ch_d = ch_q;
    cur_d = cur_q;
    idx_d = idx_q;
    tlen_d = tlen_q;
    tfunc_d = tfunc_q;
    tsum_d = tsum_q;
    last_d = last_q;
    ref_d = tx_start && !tx_go;
    case (ts_q)
      mac_pkg::MAC_T_IDLE: begin
        if (tx_go) begin
          ts_d = mac_pkg::MAC_T_START;
          ch_d = mac_pkg::MAC_CHAR_START;
          idx_d = 8'h00;
          tsum_d = 8'h00;
          last_d = 1'b0;
          tlen_d = len_cap;
          tfunc_d = tx_func;
        end
      end
      mac_pkg::MAC_T_START: begin
        if (tx_char_ready) begin
          ts_d = mac_pkg::MAC_T_LOAD;
        end
      end
      mac_pkg::MAC_T_LOAD: begin
        if (have) begin
          ts_d = mac_pkg::MAC_T_HI;
          cur_d = load_byte;
          ch_d = enc_hi;
          tsum_d = tsum_q + load_byte;
          idx_d = idx_q + 8'h01;
          last_d = ({1'b0, idx_q} >= {1'b0, tlen_q} + 9'h002);
        end
      end
      mac_pkg::MAC_T_HI: begin
        if (tx_char_ready) begin
          ts_d = mac_pkg::MAC_T_LO;
          ch_d = enc_lo;
        end
      end
      mac_pkg::MAC_T_LO: begin
        if (tx_char_ready && last_q) begin
          ts_d = mac_pkg::MAC_T_CR;
          ch_d = mac_pkg::MAC_CHAR_CR;
        end else if (tx_char_ready) begin
          ts_d = mac_pkg::MAC_T_LOAD;
        end
      end
      mac_pkg::MAC_T_CR: begin
        if (tx_char_ready) begin
          ts_d = mac_pkg::MAC_T_LF;
          ch_d = mac_pkg::MAC_CHAR_LF;
        end
      end
      mac_pkg::MAC_T_LF: begin
        if (tx_char_ready) begin
          ts_d = mac_pkg::MAC_T_IDLE;
        end
      end
      default: begin
        ts_d = mac_pkg::MAC_T_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ts_q <= mac_pkg::MAC_T_IDLE;
      ch_q <= 8'h00;
      cur_q <= 8'h00;
      idx_q <= 8'h00;
      tlen_q <= 8'h00;
      tfunc_q <= 8'h00;
      tsum_q <= 8'h00;
      last_q <= 1'b0;
      ref_q <= 1'b0;
    end else begin
      ts_q <= ts_d;
      ch_q <= ch_d;
      cur_q <= cur_d;
      idx_q <= idx_d;
      tlen_q <= tlen_d;
      tfunc_q <= tfunc_d;
      tsum_q <= tsum_d;
      last_q <= last_d;
      ref_q <= ref_d;
    end
  end

  assign tx_char = ch_q;
  assign tx_char_valid = (ts_q != mac_pkg::MAC_T_IDLE) && (ts_q != mac_pkg::MAC_T_LOAD);
  assign tx_busy = (ts_q != mac_pkg::MAC_T_IDLE);
  assign tx_refused = ref_q;

  // ==========================================================
  // assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sequence s_cr_sent;
    tx_char_valid && tx_char_ready && tx_char == mac_pkg::MAC_CHAR_CR;
  endsequence
  sequence s_lf_shown;
    tx_char_valid && tx_char == mac_pkg::MAC_CHAR_LF;
  endsequence

  a_tx_start_colon: assert property (tx_go |=> tx_char_valid && tx_char == 8'h3A)
    else $error("reply does not open with a colon");
  a_rx_colon_restart: assert property (
    rx_char_valid && rx_char == 8'h3A |=> rs_q == mac_pkg::MAC_R_BODY && cnt_q == 8'h00)
    else $error("colon did not restart the parser");
  a_tx_cr_lf: assert property (s_cr_sent |=> s_lf_shown)
    else $error("carriage return not followed by line feed");
  a_tx_hex_chars: assert property (
    ts_q == mac_pkg::MAC_T_HI || ts_q == mac_pkg::MAC_T_LO |->
    (tx_char >= 8'h30 && tx_char <= 8'h39) || (tx_char >= 8'h41 && tx_char <= 8'h46))
    else $error("non hex character inside reply body");
  a_rx_len_limit: assert property (rx_frame_valid |-> rx_len <= 8'd205)
    else $error("accepted frame with too much data");
  a_rx_addr_ok: assert property (
    rx_frame_valid |-> rx_addr == 8'h00 || (rx_addr == own_addr && own_addr != 8'hFF))
    else $error("accepted frame for another station");
  a_bcast_silent: assert property (
    rx_frame_valid && rx_broadcast && !$past(pend_q) |-> !reply_req ##1 !tx_busy)
    else $error("broadcast frame armed a reply");
  a_reply_armed: assert property (rx_frame_valid && !rx_broadcast |-> reply_req)
    else $error("good unicast frame did not arm a reply");
  a_rx_after_lf: assert property (
    rx_frame_valid |-> $past(rx_char_valid && rx_char == 8'h0A) && $past(rs_q) == mac_pkg::MAC_R_LF)
    else $error("frame accepted without terminator");
  a_tx_check_zero: assert property (
    ts_q == mac_pkg::MAC_T_LOAD && last_d && have |=> tsum_q == 8'h00)
    else $error("sent check byte does not cancel the sum");
  a_read_limit: assert property (
    tx_go && tx_func == 8'h03 |=> tlen_q <= 8'd200)
    else $error("read reply longer than 100 words");

endmodule

// ### tb/mac_master_model.sv
/*
  master model on the character side of the codec: sends framed requests
  and collects reply characters with prompt or slow acceptance.
  assumes ref_clk from the bench; all changes land 1 ns after a rising edge.
*/
`timescale 1ns/1ps
module mac_master_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // characters to the slave
  output logic rx_char_valid,
  output logic [7:0] rx_char,
  // characters from the slave
  input wire logic tx_char_valid,
  input wire logic [7:0] tx_char,
  output logic tx_char_ready
);
  // ==========================================================
  // state
  logic [7:0] got_q[$];
  logic slow;
  logic [1:0] pace_q;

  initial begin
    rx_char_valid = 1'b0;
    rx_char = 8'h00;
    tx_char_ready = 1'b0;
    slow = 1'b0;
    pace_q = 2'd0;
  end

  // ==========================================================
  // reply capture, stalls when slow
  // taken at the falling edge, where valid, ready and the character are settled
  always @(negedge ref_clk) begin
    if (tx_char_valid === 1'b1 && tx_char_ready === 1'b1) got_q.push_back(tx_char);
  end

  always @(posedge ref_clk) begin
    pace_q <= pace_q + 2'd1;
    #1 tx_char_ready = arst_n && (!slow || pace_q == 2'd0);
  end

  // ==========================================================
  // request side
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
  endfunction

  task automatic send_chr(input logic [7:0] c);
    rx_char_valid = 1'b1;
    rx_char = c;
    @(posedge ref_clk);
    #1;
  endtask

  // line released: show the inverse of the last character
  task automatic idle();
    rx_char_valid = 1'b0;
    rx_char = ~rx_char;
  endtask

  task automatic send_byte(input logic [7:0] v);
    send_chr(hx(v[7:4]));
    send_chr(hx(v[3:0]));
  endtask

  task automatic send_raw(input logic [7:0] c[$]);
    foreach (c[i]) send_chr(c[i]);
    idle();
  endtask

  task automatic send_frame(input logic [7:0] b[$], input logic [7:0] bad);
    logic [7:0] s;
    s = 8'h00;
    send_chr(8'h3A);
    foreach (b[i]) begin
      s = s + b[i];
      send_byte(b[i]);
    end
    send_byte((~s + 8'h01) ^ bad);
    send_chr(8'h0D);
    send_chr(8'h0A);
    idle();
  endtask
endmodule

// ### tb/mac_frame_codec_test.sv
/*
  self-checking bench for the frame codec: requests through the master
  model, replies fed through the byte handshake, outcomes checked.
  assumes the design package is compiled first.
*/
`timescale 1ns/1ps
module mac_frame_codec_test;
  typedef logic [7:0] mac_bq_t[$];
  // ==========================================================
  // signals
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] own_addr = 8'h01;
  logic rx_char_valid, rx_frame_valid, rx_broadcast, rx_drop;
  logic [7:0] rx_char, rx_addr, rx_func, rx_len, rx_rd_data, tx_char;
  logic [2:0] rx_drop_code, drop_seen;
  logic rx_rd_en = 1'b0;
  logic [7:0] rx_rd_idx = 8'h00;
  logic reply_req, tx_refused, tx_busy, tx_byte_ready, tx_char_valid, tx_char_ready;
  logic tx_start = 1'b0;
  logic [7:0] tx_func = 8'h00;
  logic [7:0] tx_len = 8'h00;
  logic tx_byte_valid = 1'b0;
  logic [7:0] tx_byte = 8'h00;
  logic [31:0] seed = 32'h6828_3b43;
  int miscompares = 0;
  int total_checks = 0;
  int n_good = 0;
  int n_drop = 0;
  mac_bq_t walk = '{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h02};

  always #12.5 ref_clk = ~ref_clk;

  mac_frame_codec mac_frame_codec_inst (.ref_clk(ref_clk), .arst_n(arst_n),
    .own_addr(own_addr), .rx_char_valid(rx_char_valid), .rx_char(rx_char),
    .rx_frame_valid(rx_frame_valid), .rx_broadcast(rx_broadcast), .rx_addr(rx_addr),
    .rx_func(rx_func), .rx_len(rx_len), .rx_drop(rx_drop), .rx_drop_code(rx_drop_code),
    .rx_rd_en(rx_rd_en), .rx_rd_idx(rx_rd_idx), .rx_rd_data(rx_rd_data),
    .reply_req(reply_req), .tx_start(tx_start), .tx_func(tx_func), .tx_len(tx_len),
    .tx_refused(tx_refused), .tx_busy(tx_busy), .tx_byte_valid(tx_byte_valid),
    .tx_byte(tx_byte), .tx_byte_ready(tx_byte_ready), .tx_char_valid(tx_char_valid),
    .tx_char(tx_char), .tx_char_ready(tx_char_ready));

  mac_master_model mac_master_model_inst (.ref_clk(ref_clk), .arst_n(arst_n),
    .rx_char_valid(rx_char_valid), .rx_char(rx_char), .tx_char_valid(tx_char_valid),
    .tx_char(tx_char), .tx_char_ready(tx_char_ready));

  // ==========================================================
  // helpers
  // pulses are counted at the falling edge, away from the launching edge
  always @(negedge ref_clk) begin
    if (rx_frame_valid === 1'b1) n_good++;
    if (rx_drop === 1'b1) begin
      n_drop++;
      drop_seen = rx_drop_code;
    end
  end

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [7:0] hc(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h41 + {4'h0, n} - 8'h0A;
  endfunction

  function automatic mac_bq_t exp_reply(input logic [7:0] a, input logic [7:0] f,
                                        input logic [7:0] d[$]);
    mac_bq_t q;
    logic [7:0] all[$];
    logic [7:0] s;
    all = {a, f, d};
    s = 8'h00;
    foreach (all[i]) s = s + all[i];
    all.push_back(8'h00 - s);
    q.push_back(8'h3A);
    foreach (all[i]) begin
      q.push_back(hc(all[i][7:4]));
      q.push_back(hc(all[i][3:0]));
    end
    q.push_back(8'h0D);
    q.push_back(8'h0A);
    return q;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic rx_case(input logic [7:0] b[$], input logic [7:0] bad, input logic [2:0] code);
    int g;
    int d;
    g = n_good;
    d = n_drop;
    mac_master_model_inst.send_frame(b, bad);
    repeat (3) @(posedge ref_clk);
    #1;
    check(n_good - g, (code == 3'd0) ? 1 : 0);
    check(n_drop - d, (code == 3'd0) ? 0 : 1);
    if (code != 3'd0) check(drop_seen, code);
    else begin
      check(rx_len, b.size() - 2);
      check(rx_func, b[1]);
      rx_rd_en = 1'b1;
      for (int i = 2; i < b.size(); i++) begin
        rx_rd_idx = 8'(i - 2);
        @(posedge ref_clk);
        #1;
        check(rx_rd_data, b[i]);
      end
      rx_rd_en = 1'b0;
    end
  endtask

  task automatic raw_case(input logic [7:0] c[$], input logic [2:0] code);
    int d;
    d = n_drop;
    mac_master_model_inst.send_raw(c);
    repeat (3) @(posedge ref_clk);
    #1;
    check(n_drop - d, 1);
    check(drop_seen, code);
  endtask

  task automatic reply(input logic [7:0] f, input logic [7:0] n, input logic [7:0] d[$]);
    mac_bq_t e;
    int k;
    e = exp_reply(own_addr, f, d);
    mac_master_model_inst.got_q.delete();
    tx_start = 1'b1;
    tx_func = f;
    tx_len = n;
    @(posedge ref_clk);
    #1;
    tx_start = 1'b0;
    foreach (d[i]) begin
      tx_byte_valid = 1'b1;
      tx_byte = d[i];
      k = 0;
      while (tx_byte_ready !== 1'b1 && k < 50) begin
        @(posedge ref_clk);
        #1;
        k++;
      end
      check(tx_byte_ready, 1);
      @(posedge ref_clk);
      #1;
    end
    tx_byte_valid = 1'b0;
    k = 0;
    while (tx_busy !== 1'b0 && k < 3000) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    check(tx_busy, 0);
    check(mac_master_model_inst.got_q.size(), e.size());
    foreach (e[i]) check(mac_master_model_inst.got_q[i], e[i]);
    check(reply_req, 0);
  endtask

  // ==========================================================
  // watchdog
  initial begin
    #(25 * 40000);
    miscompares++;
    wrap_up();
  end

  // ==========================================================
  // scenarios
  initial begin
    mac_bq_t b;
    repeat (5) @(posedge ref_clk);
    #1;
    arst_n = 1'b1;
    check(reply_req, 0);
    check(tx_char_valid, 0);
    rx_case('{8'h00, 8'h06, 8'h00, 8'h01, 8'h00, 8'h05}, 8'h00, 3'd0);
    check(rx_broadcast, 1);
    check(reply_req, 0);
    tx_start = 1'b1;
    @(posedge ref_clk);
    #1;
    tx_start = 1'b0;
    check(tx_refused, 1);
    rx_case(walk, 8'h00, 3'd0);
    check(rx_addr, 8'h01);
    check(reply_req, 1);
    reply(8'h03, 8'h05, '{8'h04, 8'h00, 8'h01, 8'h00, 8'h02});
    rx_case('{8'h02, 8'h03, 8'h00}, 8'h00, 3'd5);
    rx_case(walk, 8'h01, 3'd4);
    raw_case('{8'h3A, 8'h30, 8'h31, 8'h61, 8'h0D, 8'h0A}, 3'd1);
    raw_case('{8'h3A, 8'h30, 8'h31, 8'h30, 8'h33, 8'h30, 8'h0D, 8'h0A}, 3'd3);
    mac_master_model_inst.send_raw('{8'h3A, 8'h30, 8'h31, 8'h30});
    rx_case(walk, 8'h00, 3'd0);
    own_addr = 8'hFF;
    rx_case('{8'hFF, 8'h03, 8'h00}, 8'h00, 3'd5);
    own_addr = 8'h01;
    b = '{8'h01, 8'h10};
    repeat (205) begin
      seed = nxt(seed);
      b.push_back(seed[7:0]);
    end
    rx_case(b, 8'h00, 3'd0);
    b.push_back(8'h5A);
    rx_case(b, 8'h00, 3'd2);
    b = b[2:201];
    mac_master_model_inst.slow = 1'b1;
    reply(8'h03, 8'd250, b);
    mac_master_model_inst.slow = 1'b0;
    repeat (12) begin
      seed = nxt(seed);
      own_addr = 8'(seed[15:8] % 254) + 8'h01;
      b = '{(seed[0] || own_addr == 8'hFE) ? own_addr : own_addr + 8'h01, seed[23:16]};
      repeat (seed[26:24]) begin
        seed = nxt(seed);
        b.push_back(seed[7:0]);
      end
      rx_case(b, 8'h00, (b[0] == own_addr) ? 3'd0 : 3'd5);
    end
    wrap_up();
  end
endmodule
